// ==== rtl/tcr_pkg.sv ====
package tcr_pkg;

  // Function shift chain length
  localparam int TCR_CHAIN_LEN = 48;
  // Trigger view delay of the external clock path, in cycles
  localparam int TCR_VIEW_DELAY = 3;
  // Control latch field positions
  localparam int TCR_BIT_A_THEN_B_N = 0;
  localparam int TCR_BIT_A_MODE = 1;
  localparam int TCR_BIT_EXT_ACTIVE = 2;
  localparam int TCR_BIT_EXT_EDGE = 3;
  localparam int TCR_BIT_EXT_EXER = 4;
  localparam int TCR_BIT_TRIG_EN = 5;
  localparam int TCR_BIT_MSB = 7;
  // Control latch reset value: A mode, trigger disabled, ext clock off
  localparam logic [7:0] TCR_CTRL_RESET = 8'h01;

  typedef enum logic [2:0] {
    TCR_MODE_A = 3'h1,
    TCR_MODE_B = 3'h2,
    TCR_MODE_ATB = 3'h4
  } tcr_mode_t;

  typedef struct packed {
    logic a_then_b_n;
    logic a_mode;
    logic ext_clock_active;
    logic ext_clock_edge_select;
    logic ext_clock_exercise;
    logic trigger_enable_bit;
  } tcr_ctrl_t;

  typedef struct packed {
    logic func_a_strobe_first;
    logic func_a_strobe_second;
    logic filter_sync_a_first;
    logic filter_sync_a_second;
    logic external_edge_enable_n;
  } tcr_func_a_t;

endpackage

// ==== rtl/tcr_trigger_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - In A or B mode, trigger output is inhibited while reset input is high.
// - In A-then-B mode, reset inhibits trigger and clears the armed state if function A is low.
// - When reset falls, triggering resumes with no processor action.
// - Reset clears the arming latch only while filtered function A is low.
// - During reset both function A edge strobes are forced low.
// - During reset external edge enable and both A sync controls go low.
// - External clock active enables clock buffers, edge detectors, view source.
// - Edge select high passes clock as is, low passes it inverted.
// - External clock inactive forces buffered clock high.
// - Exercise control forces a low clock level, not in alternate logic family.
// - Trigger view shows trigger output, or external clock when active.
// - External clock view path is delayed to align with other traces.
// - Control latch takes all eight data bits on mode strobe rising edge.
// - Trigger enable bit low acts as internal reset of trigger output.
// - Function shift chain of 48 bits shifts in data msb per strobe.
// - Last chain stage is returned to processor as a test bit.
// - Mode code: A is 1/0, B is 1/1, A-then-B is 0/1.
// - In A-then-B, A arms; next B gives one pulse and disarms.
module tcr_trigger_control
  import tcr_pkg::*;
#(
  parameter int CHAIN_LEN = TCR_CHAIN_LEN,
  parameter int VIEW_DELAY = TCR_VIEW_DELAY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Processor write side
  input wire logic [7:0] filtered_data_bus,
  input wire logic mode_latch_write_strobe,
  input wire logic function_shift_strobe,
  output logic shift_test_bit,
  // Pins and jumper
  input wire logic trigger_reset_in,
  input wire logic ext_clock_in,
  input wire logic ext_ecl_select,
  // From filters and edge detectors
  input wire logic filtered_function_a,
  input wire logic filtered_function_b,
  input wire logic func_a_strobe_first_in,
  input wire logic func_a_strobe_second_in,
  input wire logic filter_sync_a_first_in,
  input wire logic filter_sync_a_second_in,
  // To trigger logic
  output logic [CHAIN_LEN-1:0] function_bits,
  output tcr_ctrl_t ctrl_out,
  output tcr_func_a_t func_a_out,
  output logic ext_buffer_enable,
  output logic buffered_ext_clock,
  output logic trigger_out,
  output logic armed,
  output logic trigger_view
);

  // Synchronisers for every asynchronous input
  logic [7:0] data_s1_reg, data_s2_reg;
  logic [8:0] pin_s1_reg, pin_s2_reg;
  logic [8:0] pin_raw;
  logic [1:0] fn_s1_reg, fn_s2_reg;
  logic mode_strobe_d_reg, shift_strobe_d_reg;

  // Each strobe and sync control keeps its own path so the two products func_a_strobe_second independent
  assign pin_raw = {mode_latch_write_strobe, function_shift_strobe, trigger_reset_in, ext_clock_in,
                    ext_ecl_select, func_a_strobe_first_in, func_a_strobe_second_in,
                    filter_sync_a_first_in, filter_sync_a_second_in};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
      fn_s1_reg <= 2'h0;
      fn_s2_reg <= 2'h0;
      mode_strobe_d_reg <= 1'b0;
      shift_strobe_d_reg <= 1'b0;
    end else begin
      data_s1_reg <= filtered_data_bus;
      data_s2_reg <= data_s1_reg;
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      fn_s1_reg <= {filtered_function_a, filtered_function_b};
      fn_s2_reg <= fn_s1_reg;
      mode_strobe_d_reg <= pin_s2_reg[8];
      shift_strobe_d_reg <= pin_s2_reg[7];
    end
  end

  // Synchronised names
  wire mode_strobe_s = pin_s2_reg[8];
  wire shift_strobe_s = pin_s2_reg[7];
  wire reset_in_s = pin_s2_reg[6];
  wire ext_clock_s = pin_s2_reg[5];
  wire ecl_sel_s = pin_s2_reg[4];
  wire strobe_first_s = pin_s2_reg[3];
  wire strobe_second_s = pin_s2_reg[2];
  wire sync_first_s = pin_s2_reg[1];
  wire sync_second_s = pin_s2_reg[0];
  wire fn_a_s = fn_s2_reg[1];
  wire fn_b_s = fn_s2_reg[0];
  wire mode_rise = mode_strobe_s & ~mode_strobe_d_reg;
  wire shift_rise = shift_strobe_s & ~shift_strobe_d_reg;

  // Control latch and shift chain
  logic [7:0] ctrl_reg;
  logic [CHAIN_LEN-1:0] chain_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= TCR_CTRL_RESET;
    end else if (mode_rise) begin
      ctrl_reg <= data_s2_reg;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chain_reg <= '0;
    end else if (shift_rise) begin
      chain_reg <= {chain_reg[CHAIN_LEN-2:0], data_s2_reg[TCR_BIT_MSB]};
    end
  end

  wire a_then_b_n = ctrl_reg[TCR_BIT_A_THEN_B_N];
  wire a_mode = ctrl_reg[TCR_BIT_A_MODE];
  wire ext_active = ctrl_reg[TCR_BIT_EXT_ACTIVE];
  wire ext_edge = ctrl_reg[TCR_BIT_EXT_EDGE];
  wire ext_exer = ctrl_reg[TCR_BIT_EXT_EXER];
  wire trig_en = ctrl_reg[TCR_BIT_TRIG_EN];

  // Mode decode
  tcr_mode_t mode;
  assign mode = (!a_then_b_n && a_mode) ? TCR_MODE_ATB :
                (a_then_b_n && a_mode) ? TCR_MODE_B : TCR_MODE_A;

  // Effective reset: pin high or trigger enable bit low
  wire inhibit = reset_in_s | ~trig_en;
  // Reset clears the arming latch only with function A low
  wire disarm_by_reset = inhibit & ~fn_a_s;

  // External clock path
  wire ext_level = ext_clock_s & ~(ext_exer & ~ecl_sel_s);
  wire ext_slope = ext_level ~^ ext_edge;
  wire ext_buffered = ext_active ? ext_slope : 1'b1;

  // A-then-B logic with registered edge detection of the functions
  logic fn_a_d_reg, fn_b_d_reg;
  logic armed_reg, trigger_reg;
  wire fn_a_rise = fn_a_s & ~fn_a_d_reg;
  wire fn_b_rise = fn_b_s & ~fn_b_d_reg;

  logic trigger_next, armed_next;
  always_comb begin
    trigger_next = 1'b0;
    armed_next = armed_reg;
    case (mode)
      TCR_MODE_A: begin
        trigger_next = fn_a_s & ~inhibit;
        armed_next = 1'b0;
      end
      TCR_MODE_B: begin
        trigger_next = fn_b_s & ~inhibit;
        armed_next = 1'b0;
      end
      TCR_MODE_ATB: begin
        if (disarm_by_reset) begin
          armed_next = 1'b0;
        end else if (armed_reg && fn_b_rise && !inhibit) begin
          trigger_next = 1'b1;
          armed_next = 1'b0;
        end else if (fn_a_rise && !inhibit) begin
          armed_next = 1'b1;
        end
      end
      default: begin
        trigger_next = 1'b0;
        armed_next = 1'b0;
      end
    endcase
  end

  // View delay line for the external clock
  logic [VIEW_DELAY-1:0] view_dly_reg;
  wire view_next = ext_active ? view_dly_reg[VIEW_DELAY-1] : trigger_next;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fn_a_d_reg <= 1'b0;
      fn_b_d_reg <= 1'b0;
      armed_reg <= 1'b0;
      trigger_reg <= 1'b0;
      view_dly_reg <= '0;
    end else begin
      fn_a_d_reg <= fn_a_s;
      fn_b_d_reg <= fn_b_s;
      armed_reg <= armed_next;
      trigger_reg <= trigger_next;
      view_dly_reg <= {view_dly_reg[VIEW_DELAY-2:0], ext_buffered};
    end
  end

  // Registered outputs
  tcr_func_a_t func_a_next;
  assign func_a_next.func_a_strobe_first = ~reset_in_s & strobe_first_s;
  assign func_a_next.func_a_strobe_second = ~reset_in_s & strobe_second_s;
  assign func_a_next.filter_sync_a_first = ~reset_in_s & sync_first_s;
  assign func_a_next.filter_sync_a_second = ~reset_in_s & sync_second_s;
  assign func_a_next.external_edge_enable_n = ~reset_in_s & ~ext_active;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_a_out <= '0;
      ctrl_out <= '0;
      function_bits <= '0;
      shift_test_bit <= 1'b0;
      ext_buffer_enable <= 1'b0;
      buffered_ext_clock <= 1'b1;
      trigger_out <= 1'b0;
      armed <= 1'b0;
      trigger_view <= 1'b0;
    end else begin
      func_a_out <= func_a_next;
      ctrl_out <= {a_then_b_n, a_mode, ext_active, ext_edge, ext_exer, trig_en};
      function_bits <= chain_reg;
      shift_test_bit <= chain_reg[CHAIN_LEN-1];
      ext_buffer_enable <= ext_active;
      buffered_ext_clock <= ext_buffered;
      trigger_out <= trigger_next;
      armed <= armed_next;
      trigger_view <= view_next;
    end
  end

  // Checks
  inhibit_ab_a: assert property (@(posedge clock) disable iff (!reset_n)
    (inhibit && mode != TCR_MODE_ATB) |=> !trigger_out) else $error("trigger not inhibited");
  disarm_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_ATB && inhibit && !fn_a_s) |=> !armed) else $error("armed not cleared");
  strobe_force_a: assert property (@(posedge clock) disable iff (!reset_n)
    reset_in_s |=> !func_a_out.func_a_strobe_first && !func_a_out.func_a_strobe_second)
    else $error("A strobes not forced low");
  sync_force_a: assert property (@(posedge clock) disable iff (!reset_n)
    reset_in_s |=> !func_a_out.filter_sync_a_first && !func_a_out.external_edge_enable_n)
    else $error("sync controls not forced low");
  ext_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    !ext_active |=> buffered_ext_clock) else $error("idle clock not high");
  latch_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    mode_rise |=> ctrl_reg == $past(data_s2_reg)) else $error("latch not loaded");
  chain_shift_a: assert property (@(posedge clock) disable iff (!reset_n)
    shift_rise |=> chain_reg[0] == $past(data_s2_reg[7])) else $error("chain did not shift");
  test_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 shift_test_bit == $past(chain_reg[CHAIN_LEN-1])) else $error("test bit wrong");
  sequence arm_seq;
    mode == TCR_MODE_ATB && armed_reg && fn_b_rise && !inhibit;
  endsequence
  fire_once_a: assert property (@(posedge clock) disable iff (!reset_n)
    arm_seq |=> trigger_out && !armed ##1 !trigger_out) else $error("A-then-B pulse wrong");

  // Clock path, view selector and mode checks
  sequence ext_on_seq;
    ext_active;
  endsequence
  // View output one cycle on lines up with the buffered clock of the delay line input
  sequence view_delayed_seq;
    trigger_view == $past(ext_buffered, VIEW_DELAY + 1);
  endsequence

  buf_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1
    |=> ext_buffer_enable == $past(ext_active))
    else $error("buffer enable wrong");
  edge_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!reset_in_s && ext_active)
    |=> !func_a_out.external_edge_enable_n)
    else $error("edge detectors not enabled");
  edge_slope_a: assert property (@(posedge clock) disable iff (!reset_n)
    ext_on_seq
    |=> buffered_ext_clock == $past(ext_level ~^ ext_edge))
    else $error("clock slope wrong");
  exer_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    (ext_active && ext_exer && !ecl_sel_s && ext_edge)
    |=> !buffered_ext_clock)
    else $error("exercise level not low");
  exer_ecl_a: assert property (@(posedge clock) disable iff (!reset_n)
    (ext_active && ecl_sel_s)
    |=> buffered_ext_clock == $past(ext_clock_s ~^ ext_edge))
    else $error("exercise acts in alternate family");
  view_trig_a: assert property (@(posedge clock) disable iff (!reset_n)
    !ext_active
    |=> trigger_view == trigger_out)
    else $error("view not trigger");
  view_delay_a: assert property (@(posedge clock) disable iff (!reset_n)
    ext_on_seq
    |=> view_delayed_seq)
    else $error("view delay wrong");
  resume_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_A && !inhibit && fn_a_s)
    |=> trigger_out)
    else $error("trigger did not resume");
  inhibit_all_a: assert property (@(posedge clock) disable iff (!reset_n)
    inhibit
    |=> !trigger_out)
    else $error("trigger not inhibited");
  trig_en_a: assert property (@(posedge clock) disable iff (!reset_n)
    !trig_en
    |=> !trigger_out)
    else $error("enable low let trigger out");
  b_mode_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_B && !inhibit)
    |=> trigger_out == $past(fn_b_s))
    else $error("B mode wrong");
  atb_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_ATB && !armed_reg)
    |=> !trigger_out)
    else $error("unarmed trigger");
  arm_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_ATB && !inhibit && fn_a_rise && !armed_reg)
    |=> armed)
    else $error("A did not arm");
  arm_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == TCR_MODE_ATB && inhibit && fn_a_s && armed_reg)
    |=> armed)
    else $error("armed cleared with A high");
  sync_second_a: assert property (@(posedge clock) disable iff (!reset_n)
    reset_in_s
    |=> !func_a_out.filter_sync_a_second)
    else $error("second sync not forced low");
  strobe_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
    !reset_in_s
    |=> func_a_out.func_a_strobe_second == $past(strobe_second_s))
    else $error("strobe not passed");
  sync_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
    !reset_in_s
    |=> func_a_out.filter_sync_a_first == $past(sync_first_s))
    else $error("sync not passed");
  chain_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    !shift_rise
    |=> chain_reg == $past(chain_reg))
    else $error("chain moved without strobe");
  ctrl_field_a: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1
    |=> ctrl_out.trigger_enable_bit == $past(trig_en))
    else $error("control field wrong");
  bits_out_a: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1
    |=> function_bits == $past(chain_reg))
    else $error("function bits wrong");

endmodule // tcr_trigger_control

// ==== bench/tcr_cpu_model.sv ====
`timescale 1ns/1ps
module tcr_cpu_model (
  // Clock
  input wire logic clock,
  // Filtered bus side
  output logic [7:0] filtered_data_bus,
  output logic mode_latch_write_strobe,
  output logic function_shift_strobe
);
  initial begin
    filtered_data_bus = 8'h00;
    mode_latch_write_strobe = 1'b0;
    function_shift_strobe = 1'b0;
  end

  // Data settles before the strobe and outlives it, then the bus is released
  task automatic xfer(input logic [7:0] d, input logic to_chain);
    @(negedge clock);
    filtered_data_bus = d;
    repeat (3) @(negedge clock);
    if (to_chain) begin
      function_shift_strobe = 1'b1;
    end else begin
      mode_latch_write_strobe = 1'b1;
    end
    repeat (3) @(negedge clock);
    mode_latch_write_strobe = 1'b0;
    function_shift_strobe = 1'b0;
    repeat (3) @(negedge clock);
    // Released bus shows no stale value
    filtered_data_bus = ~d;
  endtask

  task automatic load_chain(input logic [47:0] p, input logic [7:0] ctrl);
    xfer(ctrl & 8'hdf, 1'b0);
    for (int i = 47; i >= 0; i--) begin
      xfer({p[i], 7'h55}, 1'b1);
    end
    xfer(ctrl, 1'b0);
  endtask
endmodule // tcr_cpu_model

// ==== bench/tcr_trigger_control_tb_top.sv ====
`timescale 1ns/1ps
module tcr_trigger_control_tb_top;
  import tcr_pkg::*;
  localparam logic [47:0] PAT = 48'h9c3a_5f0e_71d2;
  logic clock, reset_n, trigger_reset_in, ext_clock_in, ext_ecl_select;
  logic filtered_function_a, filtered_function_b;
  logic [7:0] filtered_data_bus;
  logic mode_latch_write_strobe, function_shift_strobe, shift_test_bit;
  logic [47:0] function_bits;
  tcr_ctrl_t ctrl_out;
  tcr_func_a_t func_a_out;
  logic ext_buffer_enable, buffered_ext_clock, trigger_out, armed, trigger_view;
  int n_mismatch, n_compared, cnt;

  tcr_cpu_model tcr_cpu_model_inst (.clock(clock), .filtered_data_bus(filtered_data_bus),
    .mode_latch_write_strobe(mode_latch_write_strobe), .function_shift_strobe(function_shift_strobe));

  tcr_trigger_control tcr_trigger_control_inst (.clock(clock), .reset_n(reset_n),
    .filtered_data_bus(filtered_data_bus), .mode_latch_write_strobe(mode_latch_write_strobe),
    .function_shift_strobe(function_shift_strobe), .shift_test_bit(shift_test_bit),
    .trigger_reset_in(trigger_reset_in), .ext_clock_in(ext_clock_in), .ext_ecl_select(ext_ecl_select),
    .filtered_function_a(filtered_function_a), .filtered_function_b(filtered_function_b),
    .func_a_strobe_first_in(1'b1), .func_a_strobe_second_in(1'b1),
    .filter_sync_a_first_in(1'b1), .filter_sync_a_second_in(1'b1),
    .function_bits(function_bits), .ctrl_out(ctrl_out), .func_a_out(func_a_out),
    .ext_buffer_enable(ext_buffer_enable), .buffered_ext_clock(buffered_ext_clock),
    .trigger_out(trigger_out), .armed(armed), .trigger_view(trigger_view));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic chkv(input logic [47:0] got, input logic [47:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic mode(input logic [7:0] d);
    tcr_cpu_model_inst.xfer(d, 1'b0);
    cyc(2);
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(negedge clock);
    n_mismatch++;
    summarize;
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    reset_n = 1'b0;
    trigger_reset_in = 1'b0;
    ext_clock_in = 1'b0;
    ext_ecl_select = 1'b0;
    filtered_function_a = 1'b0;
    filtered_function_b = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(3);
    chkv(ctrl_out, 48'h20, "ctrl reset");
    chk1(buffered_ext_clock, 1'b1, "clk idle high");
    mode(8'h2a);
    chkv(ctrl_out, 48'h15, "latch 2a");
    mode(8'h15);
    chkv(ctrl_out, 48'h2a, "latch 15");
    tcr_cpu_model_inst.load_chain(PAT, 8'h21);
    chkv(function_bits, PAT, "chain");
    chk1(shift_test_bit, PAT[47], "test bit");
    filtered_function_a = 1'b1;
    cyc(4);
    chk1(trigger_out, 1'b1, "A mode trig");
    trigger_reset_in = 1'b1;
    cyc(4);
    chk1(trigger_out, 1'b0, "reset inhibit");
    chkv(func_a_out, 48'h0, "strobes forced");
    trigger_reset_in = 1'b0;
    cyc(4);
    chk1(trigger_out, 1'b1, "resume");
    chkv(func_a_out[4:1], 48'hf, "strobes pass");
    mode(8'h01);
    chk1(trigger_out, 1'b0, "enable low");
    mode(8'h23);
    chk1(trigger_out, 1'b0, "B ignores A");
    filtered_function_b = 1'b1;
    cyc(4);
    chk1(trigger_out, 1'b1, "B mode trig");
    filtered_function_a = 1'b0;
    filtered_function_b = 1'b0;
    mode(8'h22);
    filtered_function_a = 1'b1;
    cyc(4);
    filtered_function_a = 1'b0;
    cyc(4);
    chk1(armed, 1'b1, "armed");
    chk1(trigger_out, 1'b0, "no trig on A");
    filtered_function_b = 1'b1;
    cnt = 0;
    repeat (8) begin
      cyc(1);
      cnt += (trigger_out === 1'b1);
    end
    chkv(cnt, 48'h1, "one pulse");
    chk1(armed, 1'b0, "disarmed");
    filtered_function_b = 1'b0;
    filtered_function_a = 1'b1;
    cyc(4);
    trigger_reset_in = 1'b1;
    cyc(4);
    chk1(armed, 1'b1, "A high holds arm");
    filtered_function_a = 1'b0;
    cyc(4);
    chk1(armed, 1'b0, "reset disarms");
    trigger_reset_in = 1'b0;
    filtered_function_b = 1'b1;
    cyc(4);
    chk1(trigger_out, 1'b0, "no trig after");
    filtered_function_b = 1'b0;
    mode(8'h2d);
    chk1(ext_buffer_enable, 1'b1, "buf on");
    chk1(buffered_ext_clock, 1'b0, "rising pass");
    chk1(trigger_view, 1'b0, "view ext");
    ext_clock_in = 1'b1;
    cyc(2);
    chk1(trigger_view, 1'b0, "view delayed");
    cyc(6);
    chk1(trigger_view, 1'b1, "view ext high");
    chk1(buffered_ext_clock, 1'b1, "clk high");
    mode(8'h25);
    chk1(buffered_ext_clock, 1'b0, "falling inv");
    mode(8'h3d);
    chk1(buffered_ext_clock, 1'b0, "exercise low");
    ext_ecl_select = 1'b1;
    cyc(4);
    chk1(buffered_ext_clock, 1'b1, "exercise ecl");
    mode(8'h21);
    chk1(buffered_ext_clock, 1'b1, "ext off high");
    chk1(ext_buffer_enable, 1'b0, "buf off");
    filtered_function_a = 1'b1;
    cyc(6);
    chk1(trigger_view, 1'b1, "view trig");
    summarize;
  end
endmodule // tcr_trigger_control_tb_top
